//--- rtl/cal_ctrl.sv
// Self-calibration controller for a four-converter core.
// Assumes a byte-wide register port synchronous to clock; one access per cycle.
`timescale 1ns/100ps
`include "cal_ctrl_defs.svh"

// Behaviour
// - Select mask bit x includes converter x; any combination allowed.
// - Select mask steers control/status and init key accesses to chosen converters.
// - Finished flag bit 7 rises when a calibration sequence completes.
// - Finish with either overrange flag high is an invalid, timed-out result.
// - Active flag bit 6 stays high throughout a running sequence.
// - High overrange flag bit 5 set at cycle end on upper saturation.
// - Low overrange flag bit 4 set at cycle end on lower saturation.
// - After overrange the engine adjusts its preset and runs another cycle, at most RETRIES times.
// - Rising edge of start bit 1 launches calibration on selected converters.
// - Enable bit 0 powers the engine; coefficients of a normal run applied only while high.
// - Averaged start rising edge calibrates all converters in averaged fashion.
// - Averaged enable set before averaged start; results applied while set.
// - Clock register bit 3 gates the calibration clock.
module cal_ctrl
  import cal_ctrl_pkg::*;
#(
  parameter int NUM_CONV   = 4,
  parameter int RUN_CYCLES = `CAL_RUN_CYCLES,
  parameter int RETRIES    = `CAL_MAX_RETRIES
) (
  input  wire logic                clock,
  input  wire logic                rst_b,
  input  wire logic                clk_enable,
  input  wire logic [11:0]         reg_addr,
  input  wire logic                reg_write,
  input  wire logic                reg_read,
  input  wire logic [7:0]          reg_wdata,
  output logic      [7:0]          reg_rdata,
  input  wire logic [NUM_CONV-1:0] sat_high,
  input  wire logic [NUM_CONV-1:0] sat_low,
  output logic                     cal_clock_gate,
  output logic      [NUM_CONV-1:0] cal_engine_on,
  output logic      [NUM_CONV-1:0] coeff_apply,
  output logic      [NUM_CONV-1:0] preset_step,
  output logic                     averaged_mode
);
  // Only four converters have select, status and readback lanes wired
  if (NUM_CONV != 4) begin : g_bad_conv
    $error("NUM_CONV must be 4");
  end
  // Run counter is eight bits and a run needs a distinct last cycle
  if (RUN_CYCLES < 2 || RUN_CYCLES > 255) begin : g_bad_run
    $error("RUN_CYCLES out of range");
  end
  if (RETRIES < 0 || RETRIES > 15) begin : g_bad_retry
    $error("RETRIES out of range");
  end

  localparam logic [7:0] RUN_LAST  = 8'(RUN_CYCLES - 1);
  localparam logic [3:0] RETRY_MAX = 4'(RETRIES);

  // Registers
  logic [NUM_CONV-1:0] select_reg;
  logic [NUM_CONV-1:0] enable_reg;
  logic [NUM_CONV-1:0] start_reg;
  logic [7:0]          init_key_reg [NUM_CONV];
  logic                avg_start_reg;
  logic                averaged_engine_enable_reg;
  logic                clk_en_reg;
  logic [3:0]          clk_hi_reg;
  logic [7:0]          reg_rdata_reg;

  // Sequencer
  cal_state_t          state_reg;
  cal_state_t          state_next;
  logic [7:0]          count_reg;
  logic [3:0]          retry_reg;
  logic [NUM_CONV-1:0] running_reg;
  logic [NUM_CONV-1:0] any_sat_reg;
  logic                avg_run_reg;
  logic [NUM_CONV-1:0] coeff_apply_reg;
  logic [NUM_CONV-1:0] preset_step_reg;
  logic                clk_gate_reg;
  logic [NUM_CONV-1:0] engine_on_reg;

  // Address decode
  wire hit_avg  = reg_addr == `ADDR_AVG_CTRL;
  wire hit_clk  = reg_addr == `ADDR_CLK_CTRL;
  wire hit_sel  = reg_addr == `ADDR_CONV_SELECT;
  wire hit_ctl  = reg_addr == `ADDR_CTRL_STATUS;
  wire hit_init = reg_addr == `ADDR_INIT_KEY;
  wire wr_avg   = clk_enable & reg_write & hit_avg;
  wire wr_clk   = clk_enable & reg_write & hit_clk;
  wire wr_sel   = clk_enable & reg_write & hit_sel;
  wire wr_ctl   = clk_enable & reg_write & hit_ctl;
  wire wr_init  = clk_enable & reg_write & hit_init;

  // Edge detection on start bits
  logic [NUM_CONV-1:0] start_rise;
  logic                avg_rise;
  wire                 avg_ok = avg_rise & averaged_engine_enable_reg & clk_en_reg;

  genvar g;
  generate
    for (g = 0; g < NUM_CONV; g++) begin : g_conv
      rising_edge_detect u_start_edge (
        .clock  (clock),
        .rst_b  (rst_b),
        .enable (clk_enable),
        .level  (start_reg[g]),
        .rise   (start_rise[g])
      );
    end
  endgenerate

  rising_edge_detect u_avg_edge (
    .clock  (clock),
    .rst_b  (rst_b),
    .enable (clk_enable),
    .level  (avg_start_reg),
    .rise   (avg_rise)
  );

  // A normal launch takes only converters that are enabled and idle, an averaged launch takes all; clock must run
  wire [NUM_CONV-1:0] launch_norm = start_rise & enable_reg & {NUM_CONV{clk_en_reg}};
  wire [NUM_CONV-1:0] launch_mask = avg_ok ? {NUM_CONV{1'b1}} : launch_norm;
  wire                launch      = (state_reg == st_idle) & (|launch_mask);

  wire                run_end  = (state_reg == st_run) & (count_reg == RUN_LAST);
  wire [NUM_CONV-1:0] sat_any  = (sat_high | sat_low) & running_reg;
  wire                retry    = (state_reg == st_check) & (|any_sat_reg) & (retry_reg != RETRY_MAX);
  wire                finish   = (state_reg == st_check) & ~retry;

  // Per-converter status
  logic [7:4] status [NUM_CONV];
  logic [NUM_CONV-1:0] applied;
  wire  [NUM_CONV-1:0] apply_allowed = avg_run_reg ?
                                       {NUM_CONV{averaged_engine_enable_reg}} : enable_reg;

  generate
    for (g = 0; g < NUM_CONV; g++) begin : g_stat
      converter_cal_status u_status (
        .clock         (clock),
        .rst_b         (rst_b),
        .enable        (clk_enable),
        .launch        (launch & launch_mask[g]),
        .finish        (finish & running_reg[g]),
        .sat_high      (run_end & sat_high[g] & running_reg[g]),
        .sat_low       (run_end & sat_low[g] & running_reg[g]),
        .apply_allowed (apply_allowed[g]),
        .status        (status[g]),
        .coeff_applied (applied[g])
      );
    end
  endgenerate

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      st_idle:  if (launch) state_next = st_run;
      st_run:   if (run_end) state_next = st_check;
      st_check: state_next = retry ? st_run : st_done;
      st_done:  state_next = st_idle;
      default:  state_next = st_idle;
    endcase
  end

  // Readback: one selected converter; several selected read as their OR
  logic [7:0] ctl_read;
  logic [7:0] init_read;
  always_comb begin
    ctl_read  = 8'h00;
    init_read = 8'h00;
    for (int i = 0; i < NUM_CONV; i++) begin
      if (select_reg[i]) begin
        ctl_read  = ctl_read | {status[i], 2'b00, start_reg[i], enable_reg[i]};
        init_read = init_read | init_key_reg[i];
      end
    end
  end

  // Unmapped addresses read zero
  logic [7:0] rd_mux;
  always_comb begin
    if (hit_avg) begin
      rd_mux = {6'h00, avg_start_reg, averaged_engine_enable_reg};
    end else if (hit_clk) begin
      rd_mux = {clk_hi_reg, clk_en_reg, 3'h0};
    end else if (hit_sel) begin
      rd_mux = {4'h0, select_reg};
    end else if (hit_ctl) begin
      rd_mux = ctl_read;
    end else if (hit_init) begin
      rd_mux = init_read;
    end else begin
      rd_mux = 8'h00;
    end
  end

  // Read data holds until the next read
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      reg_rdata_reg <= 8'h00;
    end else if (clk_enable && reg_read) begin
      reg_rdata_reg <= rd_mux;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      select_reg <= `RST_CONV_SELECT;
    end else if (wr_sel) begin
      select_reg <= reg_wdata[NUM_CONV-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      avg_start_reg              <= 1'b0;
      averaged_engine_enable_reg <= 1'b0;
    end else if (wr_avg) begin
      avg_start_reg              <= reg_wdata[`BIT_AVG_START];
      averaged_engine_enable_reg <= reg_wdata[`BIT_AVG_ENABLE];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      clk_en_reg <= 1'b0;
      clk_hi_reg <= `RST_CLK_CTRL_HI;
    end else if (wr_clk) begin
      clk_en_reg <= reg_wdata[`BIT_CLK_EN];
      clk_hi_reg <= reg_wdata[7:4];
    end
  end

  // Control bits land only in the selected converters
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      enable_reg <= '0;
      start_reg  <= '0;
    end else begin
      for (int i = 0; i < NUM_CONV; i++) begin
        if (wr_ctl && select_reg[i]) begin
          start_reg[i]  <= reg_wdata[`BIT_START];
          enable_reg[i] <= reg_wdata[`BIT_ENABLE];
        end
      end
    end
  end

  // Init key array has no reset cost beyond four bytes
  always_ff @(posedge clock) begin
    for (int i = 0; i < NUM_CONV; i++) begin
      if (!rst_b) begin
        init_key_reg[i] <= `RST_INIT_KEY;
      end else if (wr_init && select_reg[i]) begin
        init_key_reg[i] <= reg_wdata;
      end
    end
  end

  // Sequencer
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_reg   <= st_idle;
      count_reg   <= 8'h00;
      retry_reg   <= 4'h0;
      running_reg <= '0;
      any_sat_reg <= '0;
      avg_run_reg <= 1'b0;
    end else if (clk_enable) begin
      state_reg <= state_next;
      if (launch) begin
        running_reg <= launch_mask;
        avg_run_reg <= avg_ok;
        retry_reg   <= 4'h0;
        count_reg   <= 8'h00;
        any_sat_reg <= '0;
      end else if (state_reg == st_run) begin
        count_reg <= run_end ? 8'h00 : count_reg + 8'h01;
        if (run_end) any_sat_reg <= sat_any;
      end else if (retry) begin
        retry_reg   <= retry_reg + 4'h1;
        any_sat_reg <= '0;
      end else if (state_reg == st_done) begin
        running_reg <= '0;
      end
    end
  end

  // Registered outputs
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      clk_gate_reg    <= 1'b0;
      engine_on_reg   <= '0;
      coeff_apply_reg <= '0;
      preset_step_reg <= '0;
    end else if (clk_enable) begin
      clk_gate_reg    <= clk_en_reg;
      engine_on_reg   <= enable_reg | {NUM_CONV{averaged_engine_enable_reg}};
      coeff_apply_reg <= applied;
      preset_step_reg <= retry ? any_sat_reg : '0;
    end
  end

  assign reg_rdata      = reg_rdata_reg;
  assign cal_clock_gate = clk_gate_reg;
  assign cal_engine_on  = engine_on_reg;
  assign coeff_apply    = coeff_apply_reg;
  assign preset_step    = preset_step_reg;
  assign averaged_mode  = avg_run_reg;
endmodule

//--- rtl/cal_ctrl_defs.svh
// Register offsets, field positions, reset values and timing counts
// for the converter self-calibration controller.
// Assumes an 8-bit serial-port register bus with a 12-bit address.
`ifndef CAL_CTRL_DEFS_SVH
`define CAL_CTRL_DEFS_SVH

`define ADDR_AVG_CTRL      12'h0e2
`define ADDR_CLK_CTRL      12'h0e7
`define ADDR_CONV_SELECT   12'h0e8
`define ADDR_CTRL_STATUS   12'h0e9
`define ADDR_INIT_KEY      12'h0ed

`define RST_AVG_CTRL       8'h00
`define RST_CLK_CTRL_HI    4'h3
`define RST_CONV_SELECT    4'hf
`define RST_INIT_KEY       8'ha6
`define INIT_KEY_ARMED     8'ha2

`define BIT_DONE           7
`define BIT_ACTIVE         6
`define BIT_ERR_HI         5
`define BIT_ERR_LO         4
`define BIT_START          1
`define BIT_ENABLE         0
`define BIT_AVG_START      1
`define BIT_AVG_ENABLE     0
`define BIT_CLK_EN         3

`define CAL_RUN_CYCLES     16
`define CAL_MAX_RETRIES    3

`endif

//--- rtl/cal_ctrl_pkg.sv
// Types shared by the calibration controller files.
// Assumes the defs header is included by the user files.
package cal_ctrl_pkg;
  typedef enum logic [1:0] {
    st_idle  = 2'b00,
    st_run   = 2'b01,
    st_check = 2'b10,
    st_done  = 2'b11
  } cal_state_t;
endpackage

//--- rtl/converter_cal_status.sv
// Calibration status of one converter: flags and applied coefficients.
// Assumes launch, finish and saturation inputs arrive as one-cycle pulses.
`timescale 1ns/100ps
`include "cal_ctrl_defs.svh"
module converter_cal_status (
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic       enable,
  input  wire logic       launch,
  input  wire logic       finish,
  input  wire logic       sat_high,
  input  wire logic       sat_low,
  input  wire logic       apply_allowed,
  output logic      [7:4] status,
  output logic            coeff_applied
);
  logic done_reg;
  logic active_reg;
  logic err_hi_reg;
  logic err_lo_reg;
  logic valid_reg;

  assign status = {done_reg, active_reg, err_hi_reg, err_lo_reg};
  // Overranged results count as a timeout and are never applied
  assign coeff_applied = valid_reg & apply_allowed;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      done_reg   <= 1'b0;
      active_reg <= 1'b0;
      err_hi_reg <= 1'b0;
      err_lo_reg <= 1'b0;
      valid_reg  <= 1'b0;
    end else if (enable) begin
      if (launch) begin
        done_reg   <= 1'b0;
        active_reg <= 1'b1;
        err_hi_reg <= 1'b0;
        err_lo_reg <= 1'b0;
        valid_reg  <= 1'b0;
      end else if (active_reg) begin
        if (sat_high) begin
          err_hi_reg <= 1'b1;
        end
        if (sat_low) begin
          err_lo_reg <= 1'b1;
        end
        if (finish) begin
          done_reg   <= 1'b1;
          active_reg <= 1'b0;
          valid_reg  <= ~(err_hi_reg | err_lo_reg | sat_high | sat_low);
        end
      end
    end
  end
endmodule

//--- rtl/rising_edge_detect.sv
// One-bit rising edge detector on a register bit.
// Assumes the input is synchronous to clock.
`timescale 1ns/100ps
module rising_edge_detect (
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic enable,
  input  wire logic level,
  output logic      rise
);
  logic last_reg;

  assign rise = level & ~last_reg;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      last_reg <= 1'b0;
    end else if (enable) begin
      last_reg <= level;
    end
  end
endmodule

//--- test/cal_ctrl_sva.sv
// Port assertions for the calibration controller.
// Assumes it is bound into every cal_ctrl instance.
`timescale 1ns/100ps
module cal_ctrl_sva #(
  parameter int NUM_CONV = 4
) (
  input wire logic                clock,
  input wire logic                rst_b,
  input wire logic                clk_enable,
  input wire logic [11:0]         reg_addr,
  input wire logic                reg_write,
  input wire logic                reg_read,
  input wire logic [7:0]          reg_wdata,
  input wire logic [7:0]          reg_rdata,
  input wire logic [NUM_CONV-1:0] sat_high,
  input wire logic [NUM_CONV-1:0] sat_low,
  input wire logic                cal_clock_gate,
  input wire logic [NUM_CONV-1:0] cal_engine_on,
  input wire logic [NUM_CONV-1:0] coeff_apply,
  input wire logic [NUM_CONV-1:0] preset_step,
  input wire logic                averaged_mode
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic rd_en;
  assign rd_en = reg_read && clk_enable;
  AST_GATE: assert property (reg_write && clk_enable && reg_addr == 12'h0e7 ##1 clk_enable |=>
    cal_clock_gate == $past(reg_wdata[3], 2)) else $error("gate bit not followed");
  AST_HOLD: assert property (!rd_en |=> $stable(reg_rdata)) else $error("read data moved");
  AST_UNMAPPED: assert property (rd_en && reg_addr == 12'h0e0 |=>
    reg_rdata == 8'h00) else $error("unmapped read not zero");
  AST_SEL_RSV: assert property (rd_en && reg_addr == 12'h0e8 |=>
    reg_rdata[7:4] == 4'h0) else $error("select spare bits set");
  AST_CTRL_RSV: assert property (rd_en && reg_addr == 12'h0e9 |=>
    reg_rdata[3:2] == 2'b00) else $error("control spare bits set");
  AST_PRESET: assert property (preset_step != 0 && clk_enable |=> preset_step == 0)
    else $error("preset pulse too long");
  AST_DONE_IDLE: assert property (rd_en && reg_addr == 12'h0e9 |=>
    !(reg_rdata[7] && reg_rdata[6])) else $error("done and active together");
  AST_RST_OUT: assert property ($rose(rst_b) |->
    cal_engine_on == 0 && coeff_apply == 0 && !cal_clock_gate) else $error("reset outputs");
  COV_PRESET: cover property (preset_step != 0);
  COV_APPLY: cover property (coeff_apply != 0);
  COV_AVG: cover property (averaged_mode);
endmodule

bind cal_ctrl cal_ctrl_sva #(.NUM_CONV(NUM_CONV)) i_cal_ctrl_sva (
  .clock(clock), .rst_b(rst_b), .clk_enable(clk_enable), .reg_addr(reg_addr),
  .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .sat_high(sat_high), .sat_low(sat_low),
  .cal_clock_gate(cal_clock_gate), .cal_engine_on(cal_engine_on),
  .coeff_apply(coeff_apply), .preset_step(preset_step), .averaged_mode(averaged_mode)
);

//--- test/tb_cal_ctrl.sv
// Self-checking bench for the calibration controller.
// Assumes the checker is bound in; inputs change on the falling edge.
`timescale 1ns/100ps
module tb_cal_ctrl;
  localparam int RETRIES = 3;
  logic        clock, rst_b, clk_enable, reg_write, reg_read;
  logic        cal_clock_gate, averaged_mode, rd_seen;
  logic [11:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, last_rd;
  logic [3:0]  sat_high, sat_low, cal_engine_on, coeff_apply, preset_step;
  logic [31:0] lfsr_state;
  logic [15:0] notes[$];
  int          miscompares, samples_checked, presets, n, base;

  // Short run keeps retries quick
  cal_ctrl #(.RUN_CYCLES(4), .RETRIES(RETRIES)) i_cal_ctrl (
    .clock(clock), .rst_b(rst_b), .clk_enable(clk_enable), .reg_addr(reg_addr),
    .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .sat_high(sat_high), .sat_low(sat_low),
    .cal_clock_gate(cal_clock_gate), .cal_engine_on(cal_engine_on),
    .coeff_apply(coeff_apply), .preset_step(preset_step), .averaged_mode(averaged_mode));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic end_sim;
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check8(input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge clock);
    reg_write = 1'b0;
    @(negedge clock);
  endtask

  // Mask of zero means the value is only kept for polling
  task automatic rd(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
    notes.push_back({m, e});
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clock);
    reg_read = 1'b0;
    @(negedge clock);
  endtask

  always @(posedge clock) begin
    rd_seen <= reg_read && clk_enable;
    if (preset_step[0] === 1'b1)
      presets <= presets + 1;
  end

  always @(negedge clock) begin
    if (rd_seen === 1'b1 && notes.size() > 0) begin
      last_rd = reg_rdata;
      if (notes[0][15:8] != 8'h00)
        check8(notes[0][7:0] & notes[0][15:8], reg_rdata & notes[0][15:8]);
      void'(notes.pop_front());
    end
  end

  task automatic wait_done;
    n = 0;
    do begin
      rd(12'h0e9, 8'h00, 8'h00);
      n++;
    end while (last_rd[7] !== 1'b1 && n < 60);
    if (last_rd[7] !== 1'b1) begin
      miscompares++;
      end_sim();
    end
  endtask

  task automatic run_cal(input logic [3:0] hi, input logic [3:0] lo, input logic [7:0] fin);
    sat_high = hi;
    sat_low = lo;
    wr(12'h0e9, 8'h01);
    wr(12'h0e9, 8'h03);
    @(negedge clock);
    rd(12'h0e9, 8'hff, 8'h43);
    wait_done();
    rd(12'h0e9, 8'hff, fin);
  endtask

  initial begin
    rst_b = 1'b0;
    clk_enable = 1'b1;
    {reg_write, reg_read} = 2'b00;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
    {sat_high, sat_low} = 8'h00;
    {miscompares, samples_checked} = 0;
    lfsr_state = 32'hc9a0;
    repeat (2) @(negedge clock);
    rst_b = 1'b1;
    rd(12'h0e8, 8'hff, 8'h0f);
    rd(12'h0e9, 8'hff, 8'h00);
    rd(12'h0ed, 8'hff, 8'ha6);
    rd(12'h0e7, 8'hff, 8'h30);
    rd(12'h0e2, 8'hff, 8'h00);
    lfsr_state = lfsr(lfsr_state);
    wr(12'h0e0, lfsr_state[7:0]);
    rd(12'h0e0, 8'hff, 8'h00);
    wr(12'h0e8, 8'hff);
    rd(12'h0e8, 8'hff, 8'h0f);
    wr(12'h0e9, 8'hfc);
    rd(12'h0e9, 8'hff, 8'h00);
    lfsr_state = lfsr(lfsr_state);
    wr(12'h0e8, 8'h05);
    wr(12'h0ed, lfsr_state[7:0]);
    for (int i = 0; i < 4; i++) begin
      wr(12'h0e8, 8'h01 << i);
      rd(12'h0ed, 8'hff, (i % 2 == 0) ? lfsr_state[7:0] : 8'ha6);
    end
    wr(12'h0e7, 8'h38);
    @(negedge clock);
    check8(8'h01, {7'h00, cal_clock_gate});
    wr(12'h0e8, 8'h01);
    wr(12'h0ed, 8'ha2);
    run_cal(4'h0, 4'h0, 8'h83);
    check8(8'h01, {4'h0, cal_engine_on});
    check8(8'h01, {4'h0, coeff_apply});
    wr(12'h0e9, 8'h02);
    @(negedge clock);
    check8(8'h00, {4'h0, coeff_apply});
    wr(12'h0e9, 8'h03);
    @(negedge clock);
    rd(12'h0e9, 8'hff, 8'h83);
    base = presets;
    run_cal(4'h1, 4'h0, 8'ha3);
    check8(8'(RETRIES), 8'(presets - base));
    check8(8'h00, {4'h0, coeff_apply});
    run_cal(4'h0, 4'h1, 8'h93);
    check8(8'h00, {4'h0, coeff_apply});
    {sat_high, sat_low} = 8'h00;
    wr(12'h0e2, 8'h01);
    wr(12'h0e2, 8'h03);
    @(negedge clock);
    wait_done();
    rd(12'h0e9, 8'hff, 8'h83);
    check8(8'h01, {7'h00, averaged_mode});
    check8(8'h0f, {4'h0, cal_engine_on});
    check8(8'h0f, {4'h0, coeff_apply});
    wr(12'h0e8, 8'h08);
    rd(12'h0e9, 8'hff, 8'h80);
    // Frozen clock enable must drop the write
    clk_enable = 1'b0;
    wr(12'h0e8, 8'h01);
    clk_enable = 1'b1;
    rd(12'h0e8, 8'hff, 8'h08);
    end_sim();
  end
endmodule
